/* core/vtpc_core.sv */
// Test pattern control: registers, pattern selection and pixel output.
// Assumes one AHB-Lite master, video timing on the same clock, and a
// display path that may stall through out_ready.
//
// Implementation choice: register access over AHB-Lite.
module vtpc_core #(
  parameter int H_ACTIVE = 1024,
  parameter int V_ACTIVE = 768,
  parameter int CNT_W = 12,
  parameter int FIFO_DEPTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Recovered video
  input wire logic vid_de,
  input wire logic vid_vs,
  input wire logic [23:0] vid_rgb,
  output logic vid_ready,
  // Video toward the display
  output logic out_valid,
  input wire logic out_ready,
  output logic [23:0] out_rgb,
  output logic out_sof,
  // Loop-through monitor transmitter
  output logic monitor_driver_powerdown
);
  localparam logic [39:0] H_GRAD =
    40'((vtpc_pkg::LEVELS << vtpc_pkg::FRAC) / H_ACTIVE);
  localparam logic [39:0] V_GRAD =
    40'((vtpc_pkg::LEVELS << vtpc_pkg::FRAC) / V_ACTIVE);
  localparam logic [39:0] H_BAR =
    40'((vtpc_pkg::BARS << vtpc_pkg::FRAC) / H_ACTIVE);
  localparam logic [CNT_W-1:0] H_HALF = CNT_W'(H_ACTIVE / 2);
  localparam logic [CNT_W-1:0] V_HALF = CNT_W'(V_ACTIVE / 2);
  localparam int LV = vtpc_pkg::FRAC;

  // Gray codes along idle, read wait, read out.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RDW = 2'b01,
    BUS_RDO = 2'b11,
    BUS_WR = 2'b10
  } vtpc_bus_t;

  typedef struct packed {
    vtpc_bus_t st;
    logic [7:0] addr;
    logic wr_ok;
    logic [31:0] rdata;
    logic pwdn;
    logic [7:0] ctl;
    logic [1:0] cfg;
    logic [7:0] red;
    logic [7:0] grn;
    logic [7:0] blu;
    logic [7:0] dwell;
    logic [CNT_W-1:0] h;
    logic [CNT_W-1:0] v;
    logic de_q;
    logic vs_q;
    logic sof_pend;
    logic [3:0] seq;
    logic [7:0] fcnt;
    logic pix_vld;
    logic [23:0] pix;
    logic pix_sof;
  } vtpc_state_t;

  vtpc_state_t q;
  vtpc_state_t d;
  logic take;
  logic acc;
  logic frame_tick;
  logic fifo_in_ready;
  logic [24:0] fifo_out;
  logic gen;
  logic compl;
  logic bars;
  logic auto_on;
  logic inv;
  logic [3:0] sel;
  logic [3:0] code;
  logic [39:0] hprod;
  logic [39:0] vprod;
  logic [39:0] bprod;
  logic [7:0] hl;
  logic [7:0] vl;
  logic [2:0] bar;
  logic [1:0] quad;
  logic [23:0] pix_c;

  assign gen = q.ctl[vtpc_pkg::GEN_BIT];
  assign compl = q.ctl[vtpc_pkg::COMPL_BIT];
  assign bars = q.ctl[vtpc_pkg::BARS_BIT];
  assign sel = q.ctl[vtpc_pkg::SEL_HI:vtpc_pkg::SEL_LO];
  assign auto_on = q.cfg[vtpc_pkg::AUTO_BIT];
  assign inv = q.cfg[vtpc_pkg::INV_BIT];
  assign code = auto_on ? q.seq : sel;

  // Multiplying by a reciprocal avoids a divider in the pixel path.
  assign hprod = 40'(q.h) * H_GRAD;
  assign vprod = 40'(q.v) * V_GRAD;
  assign bprod = 40'(q.h) * H_BAR;
  assign hl = hprod[LV+7:LV];
  assign vl = vprod[LV+7:LV];
  assign bar = bprod[LV+2:LV];
  assign quad = {q.v >= V_HALF, q.h >= H_HALF};

  function automatic logic [23:0] code_color(input logic [3:0] c,
    input logic [7:0] h, input logic [7:0] v, input logic [23:0] cust);
    logic [23:0] r;
    r = vtpc_pkg::COL_BLACK;
    case (c)
      vtpc_pkg::CODE_WHITE: r = vtpc_pkg::COL_WHITE;
      vtpc_pkg::CODE_BLACK: r = vtpc_pkg::COL_BLACK;
      vtpc_pkg::CODE_RED: r = vtpc_pkg::COL_RED;
      vtpc_pkg::CODE_GREEN: r = vtpc_pkg::COL_GREEN;
      vtpc_pkg::CODE_BLUE: r = vtpc_pkg::COL_BLUE;
      vtpc_pkg::CODE_HGRAY: r = {h, h, h};
      vtpc_pkg::CODE_HRED: r = {h, 16'h0000};
      vtpc_pkg::CODE_HGRN: r = {8'h00, h, 8'h00};
      vtpc_pkg::CODE_HBLU: r = {16'h0000, h};
      vtpc_pkg::CODE_VGRAY: r = {v, v, v};
      vtpc_pkg::CODE_VRED: r = {v, 16'h0000};
      vtpc_pkg::CODE_VGRN: r = {8'h00, v, 8'h00};
      vtpc_pkg::CODE_VBLU: r = {16'h0000, v};
      vtpc_pkg::CODE_CUSTOM: r = cust;
      // Reserved codes show black rather than stale data.
      default: r = vtpc_pkg::COL_BLACK;
    endcase
    return r;
  endfunction : code_color

  always_comb
  begin
    pix_c = vid_rgb;
    if (gen)
    begin
      if (compl)
        pix_c = (q.h[0] ^ q.v[0]) ? vtpc_pkg::COL_WHITE
                                  : vtpc_pkg::COL_BLACK;
      else if (bars)
        pix_c = vtpc_pkg::BAR_COLORS[bar];
      else if (auto_on && q.seq == vtpc_pkg::CODE_QUAD)
        pix_c = q.ctl[vtpc_pkg::QFLIP_BIT] ? vtpc_pkg::QUAD_FLIP[quad]
                                           : vtpc_pkg::QUAD_NORM[quad];
      else
        pix_c = code_color(code, hl, vl, {q.red, q.grn, q.blu});
      if (inv)
        pix_c = ~pix_c;
    end
  end

  assign take = hsel && htrans == vtpc_pkg::HTRANS_NONSEQ && hready;
  assign vid_ready = !q.pix_vld || fifo_in_ready;
  assign acc = vid_de && vid_ready;
  assign frame_tick = vid_vs && !q.vs_q;

  always_comb
  begin
    d = q;
    // Register writes commit in the data phase of the transfer.
    if (q.st == BUS_WR && q.wr_ok)
    begin
      case (q.addr)
        vtpc_pkg::IDX_MON_PWR: d.pwdn = hwdata[vtpc_pkg::PWDN_BIT];
        vtpc_pkg::IDX_PG_CTL: d.ctl = hwdata[7:0];
        vtpc_pkg::IDX_PG_CFG: d.cfg = hwdata[1:0];
        vtpc_pkg::IDX_RED: d.red = hwdata[7:0];
        vtpc_pkg::IDX_GRN: d.grn = hwdata[7:0];
        vtpc_pkg::IDX_BLU: d.blu = hwdata[7:0];
        vtpc_pkg::IDX_DWELL: d.dwell = hwdata[7:0];
        default: d.wr_ok = 1'b0;
      endcase
    end
    if (q.st == BUS_RDW)
    begin
      case (q.addr)
        vtpc_pkg::IDX_MON_PWR: d.rdata = 32'(q.pwdn);
        vtpc_pkg::IDX_PG_CTL: d.rdata = 32'(q.ctl);
        vtpc_pkg::IDX_PG_CFG: d.rdata = 32'(q.cfg);
        vtpc_pkg::IDX_RED: d.rdata = 32'(q.red);
        vtpc_pkg::IDX_GRN: d.rdata = 32'(q.grn);
        vtpc_pkg::IDX_BLU: d.rdata = 32'(q.blu);
        vtpc_pkg::IDX_DWELL: d.rdata = 32'(q.dwell);
        vtpc_pkg::IDX_STATUS: d.rdata = 32'({gen, q.seq});
        default: d.rdata = '0;
      endcase
      d.st = BUS_RDO;
    end
    else if (take)
    begin
      d.addr = haddr[vtpc_pkg::ADDR_HI:vtpc_pkg::ADDR_LO];
      d.wr_ok = hsize == vtpc_pkg::HSIZE_WORD;
      d.st = hwrite ? BUS_WR : BUS_RDW;
    end
    else
      d.st = BUS_IDLE;

    // Pixel position within the active region.
    d.vs_q = vid_vs;
    d.de_q = vid_de;
    if (frame_tick)
    begin
      d.h = '0;
      d.v = '0;
    end
    else if (q.de_q && !vid_de)
    begin
      d.h = '0;
      d.v = q.v + 1'b1;
    end
    else if (acc)
      d.h = q.h + 1'b1;

    // A dwell of zero advances on every frame.
    if (auto_on && frame_tick)
    begin
      if (9'(q.fcnt) + 9'h001 >= 9'(q.dwell))
      begin
        d.fcnt = '0;
        d.seq = (q.seq == vtpc_pkg::CODE_QUAD) ? vtpc_pkg::CODE_FIRST
                                               : q.seq + 1'b1;
      end
      else
        d.fcnt = q.fcnt + 1'b1;
    end
    else if (!auto_on)
      d.fcnt = '0;

    // Output stage; a held pixel stalls the source through vid_ready.
    if (fifo_in_ready)
      d.pix_vld = 1'b0;
    if (acc)
    begin
      d.pix_vld = 1'b1;
      d.pix = pix_c;
      d.pix_sof = q.sof_pend;
      d.sof_pend = 1'b0;
    end
    if (frame_tick)
      d.sof_pend = 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= BUS_IDLE;
      q.pwdn <= vtpc_pkg::RST_MON_PWR[vtpc_pkg::PWDN_BIT];
      q.ctl <= vtpc_pkg::RST_PG_CTL;
      q.cfg <= vtpc_pkg::RST_PG_CFG;
      q.red <= vtpc_pkg::RST_LEVEL;
      q.grn <= vtpc_pkg::RST_LEVEL;
      q.blu <= vtpc_pkg::RST_LEVEL;
      q.dwell <= vtpc_pkg::RST_DWELL;
      q.seq <= vtpc_pkg::CODE_FIRST;
    end
    else
      q <= d;
  end

  vtpc_fifo #(
    .W(25),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(q.pix_vld),
    .in_ready(fifo_in_ready),
    .in_data({q.pix_sof, q.pix}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

  assign out_rgb = fifo_out[23:0];
  assign out_sof = fifo_out[24];
  assign hreadyout = q.st != BUS_RDW;
  assign hresp = vtpc_pkg::HRESP_OKAY;
  assign hrdata = q.rdata;
  assign monitor_driver_powerdown = q.pwdn;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_wr(logic [7:0] idx);
    q.st == BUS_WR && q.wr_ok && q.addr == idx;
  endsequence
  sequence s_fix(logic [3:0] c);
    acc && gen && !compl && !bars && !auto_on && sel == c;
  endsequence
  sequence s_rd_take;
    take && !hwrite && q.st != BUS_RDW;
  endsequence

  chk_pwdn_write:
    assert property (s_wr(vtpc_pkg::IDX_MON_PWR) |=>
      monitor_driver_powerdown == $past(hwdata[vtpc_pkg::PWDN_BIT]))
    else $error("monitor power-down does not follow the write");
  chk_sel_solid:
    assert property (s_fix(vtpc_pkg::CODE_WHITE) |=>
      q.pix == (inv ? vtpc_pkg::COL_BLACK : vtpc_pkg::COL_WHITE))
    else $error("solid white or its inversion not produced");
  chk_solid_red:
    assert property (s_fix(vtpc_pkg::CODE_RED) ##0 !inv |=>
      q.pix == vtpc_pkg::COL_RED)
    else $error("red solid field wrong");
  chk_auto_hold:
    assert property (auto_on && !frame_tick |=> $stable(q.seq))
    else $error("pattern moved without a frame boundary");
  chk_auto_step:
    assert property (auto_on && frame_tick &&
      9'(q.fcnt) + 9'h001 >= 9'(q.dwell) |=> q.seq != $past(q.seq))
    else $error("auto-advance did not step after dwell");
  chk_hgrad_left:
    assert property (s_fix(vtpc_pkg::CODE_HRED) ##0 !inv && q.h == '0
      |=> q.pix == vtpc_pkg::COL_BLACK)
    else $error("horizontal gradient does not start black");
  chk_vgrad_green:
    assert property (s_fix(vtpc_pkg::CODE_VGRN) ##0 !inv |=>
      q.pix[23:16] == 8'h00 && q.pix[7:0] == 8'h00)
    else $error("vertical green gradient has red or blue");
  chk_grad_span:
    assert property (s_fix(vtpc_pkg::CODE_HGRAY) ##0 !inv &&
      q.h == H_HALF |=> q.pix[15:8] == 8'(vtpc_pkg::LEVELS / 2))
    else $error("gradient not spread over the active width");
  chk_custom:
    assert property (s_fix(vtpc_pkg::CODE_CUSTOM) ##0 !inv |=>
      q.pix == $past({q.red, q.grn, q.blu}))
    else $error("custom colour not taken from level registers");
  chk_compl_prio:
    assert property (acc && gen && compl && !inv &&
      q.h == '0 && q.v == '0 |=> q.pix == vtpc_pkg::COL_BLACK)
    else $error("compliance pattern not given precedence");
  chk_bars_first:
    assert property (acc && gen && !compl && bars && !inv &&
      q.h == '0 |=> q.pix == vtpc_pkg::COL_WHITE)
    else $error("first colour bar is not white");
  chk_quad_flip:
    assert property (acc && gen && !compl && !bars && auto_on && !inv &&
      q.seq == vtpc_pkg::CODE_QUAD && quad == 2'h0 |=>
      q.pix == ($past(q.ctl[vtpc_pkg::QFLIP_BIT]) ?
      vtpc_pkg::COL_BLUE : vtpc_pkg::COL_YELLOW))
    else $error("quadrant band order wrong");
  chk_gen_off:
    assert property (acc && !gen |=> q.pix == $past(vid_rgb))
    else $error("video not passed through while generator stopped");
  chk_read_wait:
    assert property (s_rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read did not answer after one wait state");
endmodule : vtpc_core

/* core/vtpc_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
module vtpc_fifo #(
  parameter int W = 25,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } vtpc_fifo_t;

  vtpc_fifo_t q;
  vtpc_fifo_t d;
  logic push;
  logic pop;

  assign in_ready = q.cnt != FULL;
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
    end
    if (pop)
      d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
    if (push && !pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end
endmodule : vtpc_fifo

/* core/vtpc_pkg.sv */
// Constants shared by the test pattern control block and its bench.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package vtpc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_MON_PWR = 8'h63;
  localparam logic [7:0] IDX_PG_CTL = 8'h64;
  localparam logic [7:0] IDX_PG_CFG = 8'h65;
  localparam logic [7:0] IDX_RED = 8'h70;
  localparam logic [7:0] IDX_GRN = 8'h71;
  localparam logic [7:0] IDX_BLU = 8'h72;
  localparam logic [7:0] IDX_DWELL = 8'h73;
  localparam logic [7:0] IDX_STATUS = 8'h74;
  localparam int ADDR_HI = 9;
  localparam int ADDR_LO = 2;
  // Reset values.
  localparam logic [7:0] RST_MON_PWR = 8'h00;
  localparam logic [7:0] RST_PG_CTL = 8'h10;
  localparam logic [1:0] RST_PG_CFG = 2'h0;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_DWELL = 8'h01;
  // Field positions.
  localparam int PWDN_BIT = 0;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 4;
  localparam int COMPL_BIT = 3;
  localparam int BARS_BIT = 2;
  localparam int QFLIP_BIT = 1;
  localparam int GEN_BIT = 0;
  localparam int INV_BIT = 1;
  localparam int AUTO_BIT = 0;
  // Pattern selection codes.
  localparam logic [3:0] CODE_WHITE = 4'h1;
  localparam logic [3:0] CODE_BLACK = 4'h2;
  localparam logic [3:0] CODE_RED = 4'h3;
  localparam logic [3:0] CODE_GREEN = 4'h4;
  localparam logic [3:0] CODE_BLUE = 4'h5;
  localparam logic [3:0] CODE_HGRAY = 4'h6;
  localparam logic [3:0] CODE_HRED = 4'h7;
  localparam logic [3:0] CODE_HGRN = 4'h8;
  localparam logic [3:0] CODE_HBLU = 4'h9;
  localparam logic [3:0] CODE_VGRAY = 4'ha;
  localparam logic [3:0] CODE_VRED = 4'hb;
  localparam logic [3:0] CODE_VGRN = 4'hc;
  localparam logic [3:0] CODE_VBLU = 4'hd;
  localparam logic [3:0] CODE_CUSTOM = 4'he;
  // Slot of the auto-advance sequence that shows the quadrant pattern.
  localparam logic [3:0] CODE_QUAD = 4'hf;
  localparam logic [3:0] CODE_FIRST = 4'h1;
  // Colours as {red, green, blue}.
  localparam logic [23:0] COL_WHITE = 24'hff_ffff;
  localparam logic [23:0] COL_BLACK = 24'h00_0000;
  localparam logic [23:0] COL_RED = 24'hff_0000;
  localparam logic [23:0] COL_GREEN = 24'h00_ff00;
  localparam logic [23:0] COL_BLUE = 24'h00_00ff;
  localparam logic [23:0] COL_YELLOW = 24'hff_ff00;
  localparam logic [23:0] COL_CYAN = 24'h00_ffff;
  localparam logic [23:0] COL_MAGENTA = 24'hff_00ff;
  // Element 0 is the leftmost bar or the top-left quadrant.
  localparam logic [7:0][23:0] BAR_COLORS = {COL_BLACK, COL_BLUE,
    COL_RED, COL_MAGENTA, COL_GREEN, COL_CYAN, COL_YELLOW, COL_WHITE};
  localparam logic [3:0][23:0] QUAD_NORM = {COL_RED, COL_BLUE,
    COL_CYAN, COL_YELLOW};
  localparam logic [3:0][23:0] QUAD_FLIP = {COL_RED, COL_YELLOW,
    COL_CYAN, COL_BLUE};
  // Scaling of gradients and bars.
  localparam int LEVELS = 256;
  localparam int BARS = 8;
  localparam int FRAC = 16;
  // Bus encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : vtpc_pkg

/* tb/tb_top.sv */
// Self-checking bench for the test pattern control block.
// Assumes the package, FIFO and core from core/ are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 16;
  localparam int V = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic vid_de = 1'b0;
  logic vid_vs = 1'b0;
  logic [23:0] vid_rgb = 24'h00_0000;
  logic vid_ready, out_valid, out_ready, out_sof;
  logic monitor_driver_powerdown;
  logic [23:0] out_rgb;
  logic stall = 1'b0;
  logic refused = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  logic [23:0] sol [5] = '{vtpc_pkg::COL_WHITE, vtpc_pkg::COL_BLACK,
    vtpc_pkg::COL_RED, vtpc_pkg::COL_GREEN, vtpc_pkg::COL_BLUE};
  logic [23:0] hue [4] = '{vtpc_pkg::COL_WHITE, vtpc_pkg::COL_RED,
    vtpc_pkg::COL_GREEN, vtpc_pkg::COL_BLUE};
  logic [23:0] bar [8] = '{vtpc_pkg::COL_WHITE, vtpc_pkg::COL_YELLOW,
    vtpc_pkg::COL_CYAN, vtpc_pkg::COL_GREEN, vtpc_pkg::COL_MAGENTA,
    vtpc_pkg::COL_RED, vtpc_pkg::COL_BLUE, vtpc_pkg::COL_BLACK};

  always #10 clk = ~clk;

  vtpc_core #(.H_ACTIVE(H), .V_ACTIVE(V)) u_dut
  (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .vid_de(vid_de), .vid_vs(vid_vs),
    .vid_rgb(vid_rgb), .vid_ready(vid_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_rgb(out_rgb), .out_sof(out_sof),
    .monitor_driver_powerdown(monitor_driver_powerdown)
  );

  vtpc_disp_model u_disp
  (
    .clk(clk), .sys_rst(sys_rst), .out_valid(out_valid),
    .out_rgb(out_rgb), .out_sof(out_sof), .out_ready(out_ready),
    .stall(stall)
  );

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Ready and read data are taken as they stood at the rising edge, before
  // the block's registers move, so every wait state is honoured.
  task automatic wait_rdy();
    do
      @(posedge clk);
    while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : wait_rdy

  task automatic bus(logic w, logic [7:0] idx, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= vtpc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= vtpc_pkg::HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus

  task automatic wr(logic [7:0] idx, logic [7:0] d);
    bus(1'b1, idx, {24'h00_0000, d});
  endtask : wr

  task automatic rd_chk(string what, logic [7:0] idx, logic [7:0] exp);
    bus(1'b0, idx, 32'h0);
    check(what, {24'h00_0000, exp}, rd);
  endtask : rd_chk

  // The source holds its pixel until the block is ready for it.
  task automatic pix(logic de, logic vs, logic [23:0] c);
    vid_de <= de;
    vid_vs <= vs;
    vid_rgb <= c;
    do
    begin
      @(negedge clk);
      if (de && vid_ready !== 1'b1)
        refused = 1'b1;
    end
    while (de && vid_ready !== 1'b1);
    @(posedge clk);
  endtask : pix

  task automatic frame(int lines, int n, logic [23:0] c);
    u_disp.pix_q.delete();
    pix(1'b0, 1'b1, c);
    pix(1'b0, 1'b0, c);
    for (int l = 0; l < lines; l++)
    begin
      for (int i = 0; i < n; i++)
        pix(1'b1, 1'b0, c);
      pix(1'b0, 1'b0, c);
    end
    // Counted at the falling edge, so the last pixel taken has settled in the display model's queue.
    for (int t = 0; t < 400 && u_disp.pix_q.size() < lines * n; t++)
      @(negedge clk);
    @(posedge clk);
  endtask : frame

  task automatic pchk(string what, int i, logic [23:0] exp);
    logic [24:0] got;
    got = 'x;
    if (i < u_disp.pix_q.size())
      got = u_disp.pix_q[i];
    check(what, {7'h0, i == 0, exp}, {7'h0, got});
  endtask : pchk

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("pwdn_rst", 32'h0, {31'h0, monitor_driver_powerdown});
    rd_chk("mon_pwr", vtpc_pkg::IDX_MON_PWR, 8'h00);
    rd_chk("pg_ctl", vtpc_pkg::IDX_PG_CTL, 8'h10);
    rd_chk("pg_cfg", vtpc_pkg::IDX_PG_CFG, 8'h00);
    rd_chk("unmapped", 8'h40, 8'h00);
    check("hresp", 32'h0, {31'h0, hresp});
    frame(1, 4, 24'h12_3456);
    pchk("pass0", 0, 24'h12_3456);
    pchk("pass3", 3, 24'h12_3456);
    // Power the monitor driver down before any run bit is set.
    wr(vtpc_pkg::IDX_MON_PWR, 8'hff);
    rd_chk("mon_pwr", vtpc_pkg::IDX_MON_PWR, 8'h01);
    check("pwdn_on", 32'h1, {31'h0, monitor_driver_powerdown});
    // Only codes 1 to 14 are ever programmed.
    for (int inv = 0; inv < 2; inv++)
    begin
      wr(vtpc_pkg::IDX_PG_CFG, {6'h0, inv[0], 1'b0});
      for (int c = 1; c <= 5; c++)
      begin
        wr(vtpc_pkg::IDX_PG_CTL, {c[3:0], 4'h1});
        frame(1, 2, 24'h12_3456);
        pchk("solid", 0, inv ? ~sol[c - 1] : sol[c - 1]);
      end
    end
    wr(vtpc_pkg::IDX_PG_CFG, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(vtpc_pkg::IDX_PG_CTL, {4'(6 + k), 4'h1});
      frame(1, H, 24'h12_3456);
      pchk("hgrad", H - 1, 24'hf0_f0f0 & hue[k]);
      wr(vtpc_pkg::IDX_PG_CTL, {4'(10 + k), 4'h1});
      frame(2, 1, 24'h12_3456);
      pchk("vgrad", 1, 24'h20_2020 & hue[k]);
    end
    wr(vtpc_pkg::IDX_PG_CTL, 8'h61);
    frame(1, H, 24'h12_3456);
    pchk("half", H / 2, 24'h80_8080);
    wr(vtpc_pkg::IDX_RED, 8'h12);
    wr(vtpc_pkg::IDX_GRN, 8'h34);
    wr(vtpc_pkg::IDX_BLU, 8'h56);
    wr(vtpc_pkg::IDX_PG_CTL, 8'he1);
    frame(1, 2, 24'h00_0000);
    pchk("custom", 1, 24'h12_3456);
    stall <= 1'b1;
    refused = 1'b0;
    wr(vtpc_pkg::IDX_PG_CTL, 8'h15);
    frame(1, H, 24'h12_3456);
    for (int b = 0; b < 8; b++)
      pchk("bars", 2 * b, bar[b]);
    check("refused", 32'h1, {31'h0, refused});
    check("drained", 32'h0, {31'h0, out_valid});
    stall <= 1'b0;
    wr(vtpc_pkg::IDX_PG_CTL, 8'h1d);
    frame(2, 2, 24'h12_3456);
    pchk("compl0", 0, vtpc_pkg::COL_BLACK);
    pchk("compl1", 1, vtpc_pkg::COL_WHITE);
    pchk("compl2", 2, vtpc_pkg::COL_WHITE);
    wr(vtpc_pkg::IDX_DWELL, 8'h02);
    wr(vtpc_pkg::IDX_PG_CTL, 8'h31);
    wr(vtpc_pkg::IDX_PG_CFG, 8'h01);
    frame(1, 1, 24'h12_3456);
    pchk("auto1", 0, vtpc_pkg::COL_WHITE);
    frame(1, 1, 24'h12_3456);
    pchk("auto2", 0, vtpc_pkg::COL_BLACK);
    rd_chk("status", vtpc_pkg::IDX_STATUS, 8'h12);
    wr(vtpc_pkg::IDX_DWELL, 8'h01);
    for (int s = 0; s < 12; s++)
    begin
      pix(1'b0, 1'b1, 24'h00_0000);
      pix(1'b0, 1'b0, 24'h00_0000);
    end
    rd_chk("status", vtpc_pkg::IDX_STATUS, 8'h1e);
    frame(V, H, 24'h12_3456);
    pchk("quad_tl", 0, vtpc_pkg::COL_YELLOW);
    pchk("quad_tr", H - 1, vtpc_pkg::COL_CYAN);
    pchk("quad_bl", H * (V - 1), vtpc_pkg::COL_BLUE);
    pchk("quad_br", H * V - 1, vtpc_pkg::COL_RED);
    // A longer dwell keeps the quadrant slot while the order flips.
    wr(vtpc_pkg::IDX_DWELL, 8'h02);
    wr(vtpc_pkg::IDX_PG_CTL, 8'h33);
    frame(V, H, 24'h12_3456);
    pchk("qflip_tl", 0, vtpc_pkg::COL_BLUE);
    pchk("qflip_bl", H * (V - 1), vtpc_pkg::COL_YELLOW);
    end_of_test();
  end
endmodule : tb_top

/* tb/vtpc_disp_model.sv */
// Display-side sink that takes pixels from the pattern control block.
// Assumes one clock and the block's asynchronous active-high reset.
module vtpc_disp_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Video from the block
  input wire logic out_valid,
  input wire logic [23:0] out_rgb,
  input wire logic out_sof,
  output logic out_ready,
  // Bench control
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_q;
  logic [24:0] pix_q[$];

  // A slow panel takes one pixel in four, so the buffer fills and refuses.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ph_q <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      if (out_valid && out_ready)
      begin
        pix_q.push_back({out_sof, out_rgb});
      end
      ph_q <= ph_q + 2'h1;
      out_ready <= !stall || (ph_q == 2'h3);
    end
  end
endmodule : vtpc_disp_model
